// ==== src/swt_device.sv ====
/*
  Device end of the single-wire link: decodes instructions, takes write
  bytes into a two-entry buffer, fetches read bytes and sends them back.
  Assumes the link input is synchronous to MCLK_IN and the host keeps its
  own timing and legality duties.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Two-bit operation field selects the transaction.
// - Bank field picks memory, control, authentication, test.
// - Address is the first location; memory starts odd.
// - Byte count excludes the checksum byte.
// - Codes 0, 3, 5, 6 raise a bus error.
// - Code 1 is one byte, registers only.
// - Code 2 is two bytes; memory writes exactly two.
// - Code 4 is four bytes, memory read, challenge.
// - Code 7 is sixteen bytes, unlocked memory reads.
// - Host never issues counts illegal for the target.
// - Host wakes the device, e.g. with a break.
// - Write, read, and read followed by write.
// - Gaps and turn-arounds of one bit time.
// - Operation 10 appends checksum after read data.
// - Checksum polynomial 1 + x^4 + x^5 + x^8.
// - Checksum cleared, then fed each sent bit.
// - Checksum byte sent last, low bit first.
// - All timing from a 532.5 kHz time base.
// - Operations: write, read, checked read, sleep.
// - Low bit first; instruction is sixteen bits.
// - One is 0.3, zero 0.7 bit-time low.
// - Chip-select mismatch ignored until the next break.
module swt_device
  import swt_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  swt_link_if.dev LINK,
  input wire logic CHIP_SEL_IN,
  output logic WR_VALID_OUT,
  input wire logic WR_READY_IN,
  output swt_pkg::swt_bank_e WR_BANK_OUT,
  output logic [7:0] WR_ADDR_OUT,
  output logic [7:0] WR_DATA_OUT,
  output logic RD_REQ_OUT,
  output swt_pkg::swt_bank_e RD_BANK_OUT,
  output logic [7:0] RD_ADDR_OUT,
  input wire logic RD_VALID_IN,
  input wire logic [7:0] RD_DATA_IN,
  output logic BUS_ERR_OUT,
  output logic SLEEP_OUT
);
  import swt_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_WRDATA = 3'b001,
    D_TURN = 3'b010,
    D_FETCH = 3'b011,
    D_TXBIT = 3'b100,
    D_IGNORE = 3'b101
  } swt_dev_st_e;

  typedef struct packed {
    swt_dev_st_e st;
    logic [7:0] div;
    logic [7:0] lw;
    logic line_q;
    logic [7:0] tcnt;
    logic [4:0] nbits;
    logic [15:0] sh;
    swt_instr_s ins;
    logic [4:0] left;
    logic [7:0] addr;
    logic [7:0] txb;
    logic [3:0] txn;
    logic [7:0] crc;
    logic crc_sent;
    logic drive;
    logic [1:0] fill;
    logic [1:0][17:0] wbuf;
    logic wr_valid;
    logic rd_req;
    logic bus_err;
    logic sleep;
  } swt_dev_s;

  swt_dev_s s_r;
  swt_dev_s s_nxt;
  logic tick;
  logic brk;
  logic bit_ev;
  logic bit_val;
  logic push;
  logic [15:0] sh_new;
  swt_instr_s ins_new;
  swt_sym_e sym;

  // Next-state logic of the whole device end.
  always_comb begin
    s_nxt = s_r;
    s_nxt.bus_err = 1'b0;
    push = 1'b0;
    tick = (s_r.div == OSC_DIV_M1);
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    sym = swt_classify(s_r.lw);
    bit_val = (sym == SYM_ONE);
    sh_new = {bit_val, s_r.sh[15:1]};
    ins_new = swt_instr_s'(sh_new);
    brk = tick && s_r.st != D_TXBIT && !LINK.line && s_r.lw == T_BRK - 8'h01;
    bit_ev = tick && s_r.st != D_TXBIT && LINK.line && !s_r.line_q && s_r.lw < T_BRK;

    // Pulse-width measurement; own pulses are masked while sending.
    if (tick) begin
      if (s_r.st == D_TXBIT) begin
        s_nxt.lw = 8'h00;
        s_nxt.line_q = 1'b1;
      end else begin
        s_nxt.line_q = LINK.line;
        if (LINK.line) begin
          s_nxt.lw = 8'h00;
        end else if (s_r.lw != 8'hff) begin
          s_nxt.lw = s_r.lw + 8'h01;
        end
      end
    end

    // The user side drains the write buffer.
    if (s_r.wr_valid && WR_READY_IN) begin
      s_nxt.wbuf[0] = s_r.wbuf[1];
      s_nxt.fill = s_r.fill - 2'h1;
    end

    // Transaction sequencing.
    case (s_r.st)
      D_IDLE: begin
        if (bit_ev && sym == SYM_BAD) begin
          s_nxt.bus_err = 1'b1;
          s_nxt.st = D_IGNORE;
        end else if (bit_ev) begin
          s_nxt.sh = sh_new;
          s_nxt.nbits = s_r.nbits + 5'h01;
          if (s_r.nbits == 5'h0f) begin
            s_nxt.ins = ins_new;
            s_nxt.nbits = 5'h00;
            s_nxt.addr = ins_new.addr;
            s_nxt.left = swt_bytes(ins_new.cnt);
            s_nxt.crc = CRC_INIT;
            s_nxt.crc_sent = 1'b0;
            // Timed from the start of the last bit, so a whole bit time follows its end.
            s_nxt.tcnt = s_r.lw - T_BT;
            if (ins_new.cs != CHIP_SEL_IN) begin
              s_nxt.st = D_IGNORE;
            end else if (ins_new.op == OP_SLEEP) begin
              s_nxt.sleep = 1'b1;
              s_nxt.st = D_IGNORE;
            end else if (swt_bytes(ins_new.cnt) == 5'h00) begin
              s_nxt.bus_err = 1'b1;
              s_nxt.st = D_IGNORE;
            end else if (ins_new.op == OP_WRITE) begin
              s_nxt.st = D_WRDATA;
            end else begin
              s_nxt.st = D_TURN;
            end
          end
        end
      end
      D_WRDATA: begin
        if (bit_ev && sym == SYM_BAD) begin
          s_nxt.bus_err = 1'b1;
          s_nxt.st = D_IGNORE;
        end else if (bit_ev) begin
          s_nxt.sh = sh_new;
          s_nxt.nbits = s_r.nbits + 5'h01;
          if (s_r.nbits == 5'h07) begin
            push = 1'b1;
            s_nxt.nbits = 5'h00;
            s_nxt.addr = s_r.addr + 8'h01;
            s_nxt.left = s_r.left - 5'h01;
            if (s_r.left == 5'h01) begin
              s_nxt.st = D_IDLE;
            end
          end
        end
      end
      D_TURN: begin
        if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
          if (s_r.tcnt == T_BT - 8'h01) begin
            s_nxt.tcnt = 8'h00;
            if (s_r.left != 5'h00) begin
              s_nxt.rd_req = 1'b1;
              s_nxt.st = D_FETCH;
            end else if (s_r.ins.op == OP_READ_CRC && !s_r.crc_sent) begin
              s_nxt.txb = s_r.crc;
              s_nxt.crc_sent = 1'b1;
              s_nxt.txn = 4'h0;
              s_nxt.st = D_TXBIT;
            end else begin
              s_nxt.st = D_IDLE;
            end
          end
        end
      end
      D_FETCH: begin
        if (s_r.rd_req && RD_VALID_IN) begin
          s_nxt.rd_req = 1'b0;
          s_nxt.txb = RD_DATA_IN;
          s_nxt.txn = 4'h0;
          s_nxt.tcnt = 8'h00;
          s_nxt.addr = s_r.addr + 8'h01;
          s_nxt.left = s_r.left - 5'h01;
          s_nxt.st = D_TXBIT;
        end
      end
      D_TXBIT: begin
        if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
          if (s_r.tcnt == T_BT - 8'h01) begin
            s_nxt.tcnt = 8'h00;
            if (!s_r.crc_sent) begin
              s_nxt.crc = swt_crc(s_r.crc, s_r.txb[0]);
            end
            s_nxt.txb = {1'b0, s_r.txb[7:1]};
            s_nxt.txn = s_r.txn + 4'h1;
            if (s_r.txn == 4'h7) begin
              s_nxt.st = D_TURN;
              // Nothing follows the last byte, so the wire is watched again at once.
              if (s_r.left == 5'h00 && (s_r.ins.op != OP_READ_CRC || s_r.crc_sent)) begin
                s_nxt.st = D_IDLE;
              end
            end
          end
        end
      end
      D_IGNORE: begin
        s_nxt.st = D_IGNORE;
      end
      default: begin
        s_nxt.st = D_IGNORE;
      end
    endcase

    // A break restarts framing from any state but sending.
    if (brk) begin
      s_nxt.st = D_IDLE;
      s_nxt.nbits = 5'h00;
      s_nxt.sleep = 1'b0;
      s_nxt.rd_req = 1'b0;
    end

    // A finished write byte enters the buffer; a full buffer is an error.
    if (push) begin
      if (s_nxt.fill == 2'h2) begin
        s_nxt.bus_err = 1'b1;
      end else begin
        s_nxt.wbuf[s_nxt.fill[0]] = {s_r.ins.bank, s_r.addr, sh_new[15:8]};
        s_nxt.fill = s_nxt.fill + 2'h1;
      end
    end
    s_nxt.wr_valid = (s_nxt.fill != 2'h0);
    s_nxt.drive = (s_nxt.st == D_TXBIT) && (s_nxt.tcnt < swt_pulse(s_nxt.txb[0]));
  end

  // State register.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s_r <= '0;
      s_r.line_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ports straight from the state register.
  assign LINK.dev_o = 1'b0;
  assign LINK.dev_oe = s_r.drive;
  assign WR_VALID_OUT = s_r.wr_valid;
  assign WR_BANK_OUT = swt_bank_e'(s_r.wbuf[0][17:16]);
  assign WR_ADDR_OUT = s_r.wbuf[0][15:8];
  assign WR_DATA_OUT = s_r.wbuf[0][7:0];
  assign RD_REQ_OUT = s_r.rd_req;
  assign RD_BANK_OUT = s_r.ins.bank;
  assign RD_ADDR_OUT = s_r.addr;
  assign BUS_ERR_OUT = s_r.bus_err;
  assign SLEEP_OUT = s_r.sleep;
endmodule : swt_device
`default_nettype wire

// ==== pkg/swt_pkg.sv ====
/*
  Shared constants, types and helpers for both ends of the single-wire link.
  Assumes one 20 MHz clock at each end and a pulled-up, open-drain wire.
*/
package swt_pkg;
  // Clock rate and the internal time base that all symbol timing uses.
  localparam longint MCLK_HZ = 20000000;
  localparam longint OSC_HZ = 532500;
  localparam logic [7:0] OSC_DIV_M1 = 8'(MCLK_HZ / OSC_HZ - 1);
  // Bit time in nanoseconds and the same in time-base ticks.
  // The link runs at the fastest of the four rates; the rate select is not built.
  localparam longint BIT_TIME_NS = 43200;
  localparam int BT_I = int'(BIT_TIME_NS * OSC_HZ / 64'd1000000000);
  localparam logic [7:0] T_BT = 8'(BT_I);
  // Transmit widths of the symbols, in per mille of a bit time.
  localparam logic [7:0] T_ONE = 8'(BT_I * 304 / 1000);
  localparam logic [7:0] T_ZERO = 8'(BT_I * 696 / 1000);
  localparam logic [7:0] T_BRKTX = 8'(BT_I * 1391 / 1000);
  // Receive windows of the symbols.
  localparam logic [7:0] T_GLITCH = 8'(BT_I * 124 / 1000);
  localparam logic [7:0] T_ONE_MAX = 8'(BT_I * 453 / 1000);
  localparam logic [7:0] T_ZERO_MIN = 8'(BT_I * 591 / 1000);
  localparam logic [7:0] T_ZERO_MAX = 8'(BT_I * 824 / 1000);
  localparam logic [7:0] T_BRK = T_BT;
  // Checksum polynomial 1 + x^4 + x^5 + x^8 in shift-right form.
  localparam logic [7:0] CRC_POLY = 8'h8c;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Location of the challenge code in the authentication bank.
  localparam logic [7:0] CHALLENGE_ADDR = 8'h01;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00, OP_READ = 2'b01, OP_READ_CRC = 2'b10, OP_SLEEP = 2'b11
  } swt_op_e;
  typedef enum logic [1:0] {
    BANK_OTP = 2'b00, BANK_CTRL = 2'b01, BANK_AUTH = 2'b10, BANK_TEST = 2'b11
  } swt_bank_e;
  typedef enum logic [1:0] {
    SYM_ONE = 2'b00, SYM_ZERO = 2'b01, SYM_BAD = 2'b10
  } swt_sym_e;
  // Instruction frame, chip select in bit 0.
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] addr;
    swt_bank_e bank;
    swt_op_e op;
    logic cs;
  } swt_instr_s;

  // Data bytes named by a byte-count code; zero marks an invalid code.
  function automatic logic [4:0] swt_bytes(input logic [2:0] code);
    case (code)
      3'h1: return 5'h01;
      3'h2: return 5'h02;
      3'h4: return 5'h04;
      3'h7: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : swt_bytes

  // Sorts a measured low-pulse width into a symbol.
  function automatic swt_sym_e swt_classify(input logic [7:0] w);
    if (w >= T_GLITCH && w <= T_ONE_MAX) return SYM_ONE;
    if (w >= T_ZERO_MIN && w <= T_ZERO_MAX) return SYM_ZERO;
    return SYM_BAD;
  endfunction : swt_classify

  // Low time of a transmitted symbol.
  function automatic logic [7:0] swt_pulse(input logic b);
    return b ? T_ONE : T_ZERO;
  endfunction : swt_pulse

  // One shift of the checksum register with the bit on the wire.
  function automatic logic [7:0] swt_crc(input logic [7:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 8'h00);
  endfunction : swt_crc

  // Whether an instruction is allowed for its target.
  function automatic logic swt_legal(input swt_instr_s i, input logic locked);
    logic ok;
    ok = 1'b0;
    case (i.bank)
      BANK_OTP: ok = i.addr[0] && ((i.op == OP_WRITE) ? (i.cnt == 3'h2) :
          (i.cnt == 3'h2 || i.cnt == 3'h4 || (i.cnt == 3'h7 && !locked)));
      BANK_AUTH: ok = i.cnt == 3'h1 || i.cnt == 3'h2 ||
          (i.cnt == 3'h4 && i.op == OP_WRITE && i.addr == CHALLENGE_ADDR);
      default: ok = i.cnt == 3'h1 || i.cnt == 3'h2;
    endcase
    return ok || i.op == OP_SLEEP;
  endfunction : swt_legal
endpackage : swt_pkg

// ==== pkg/swt_link_if.sv ====
/*
  The single wire between host and device.
  Assumes a pull-up holds the wire high when neither end pulls it low.
*/
`timescale 1ns/1ps
`default_nettype none
interface swt_link_if;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;
  logic line;
  // Wired-AND of both open-drain drivers over the pull-up.
  assign line = !((dev_oe && !dev_o) || (host_oe && !host_o));
  modport dev (input line, output dev_o, output dev_oe);
  modport host (input line, output host_o, output host_oe);
endinterface : swt_link_if
`default_nettype wire

// ==== src/swt_host.sv ====
/*
  Host end of the single-wire link: checks and sends instructions, sends
  write bytes, collects read bytes and checks the appended checksum.
  Assumes the link input is synchronous to MCLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module swt_host
  import swt_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  swt_link_if.host LINK,
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input wire swt_pkg::swt_instr_s CMD_FRAME_IN,
  input wire logic CMD_BREAK_IN,
  input wire logic OTP_LOCKED_IN,
  output logic CMD_ERR_OUT,
  input wire logic WR_VALID_IN,
  output logic WR_READY_OUT,
  input wire logic [7:0] WR_DATA_IN,
  output logic RD_VALID_OUT,
  output logic [7:0] RD_DATA_OUT,
  output logic DONE_OUT,
  output logic CRC_ERR_OUT
);
  import swt_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_BREAK = 3'b001, H_SETTLE = 3'b010, H_TXBIT = 3'b011,
    H_FETCH = 3'b100, H_RX = 3'b101, H_TURN = 3'b110
  } swt_host_st_e;

  typedef struct packed {
    swt_host_st_e st;
    logic [7:0] div;
    logic [7:0] lw;
    logic line_q;
    logic [7:0] tcnt;
    swt_instr_s ins;
    logic [15:0] sh;
    logic [4:0] txn;
    logic data_ph;
    logic [4:0] left;
    logic [7:0] crc;
    logic bad;
    logic drive;
    logic rdy;
    logic wr_rdy;
    logic cmd_err;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic crc_err;
  } swt_host_s;

  swt_host_s s_r;
  swt_host_s s_nxt;
  logic tick;
  logic bit_ev;
  logic bit_val;

  // Next-state logic of the whole host end.
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd_err = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.done = 1'b0;
    tick = (s_r.div == OSC_DIV_M1);
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    bit_val = (swt_classify(s_r.lw) == SYM_ONE);
    bit_ev = tick && s_r.st == H_RX && LINK.line && !s_r.line_q;
    // Pulse widths are only measured while listening.
    if (tick) begin
      s_nxt.line_q = (s_r.st == H_RX) ? LINK.line : 1'b1;
      s_nxt.lw = (s_r.st != H_RX || LINK.line) ? 8'h00 :
          (s_r.lw == 8'hff) ? s_r.lw : s_r.lw + 8'h01;
    end
    case (s_r.st)
      H_IDLE: begin
        if (CMD_VALID_IN && s_r.rdy) begin
          if (!swt_legal(CMD_FRAME_IN, OTP_LOCKED_IN)) begin
            s_nxt.cmd_err = 1'b1;
          end else begin
            s_nxt.ins = CMD_FRAME_IN;
            s_nxt.sh = CMD_FRAME_IN;
            s_nxt.txn = 5'h00;
            s_nxt.data_ph = 1'b0;
            s_nxt.tcnt = 8'h00;
            s_nxt.left = swt_bytes(CMD_FRAME_IN.cnt);
            s_nxt.st = CMD_BREAK_IN ? H_BREAK : H_TXBIT;
          end
        end
      end
      H_BREAK, H_SETTLE, H_TURN: begin
        if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
          if (s_r.st == H_BREAK && s_r.tcnt == T_BRKTX - 8'h01) begin
            s_nxt.tcnt = 8'h00;
            s_nxt.st = H_SETTLE;
          end else if (s_r.st != H_BREAK && s_r.tcnt == T_BT - 8'h01) begin
            s_nxt.tcnt = 8'h00;
            s_nxt.done = (s_r.st == H_TURN);
            s_nxt.crc_err = s_r.bad || (s_r.ins.op == OP_READ_CRC && s_r.crc != 8'h00);
            s_nxt.st = (s_r.st == H_TURN) ? H_IDLE : H_TXBIT;
          end
        end
      end
      H_TXBIT: begin
        if (tick) begin
          s_nxt.tcnt = s_r.tcnt + 8'h01;
          if (s_r.tcnt == T_BT - 8'h01) begin
            s_nxt.tcnt = 8'h00;
            s_nxt.sh = {1'b0, s_r.sh[15:1]};
            s_nxt.txn = s_r.txn + 5'h01;
            if (s_r.txn == (s_r.data_ph ? 5'h07 : 5'h0f)) begin
              s_nxt.crc = CRC_INIT;
              s_nxt.bad = 1'b0;
              s_nxt.txn = 5'h00;
              if (s_r.ins.op == OP_WRITE && s_r.left != 5'h00) begin
                s_nxt.st = H_FETCH;
              end else if (s_r.ins.op == OP_READ || s_r.ins.op == OP_READ_CRC) begin
                s_nxt.left = s_r.left + {4'h0, s_r.ins.op == OP_READ_CRC};
                s_nxt.st = H_RX;
              end else begin
                s_nxt.done = 1'b1;
                s_nxt.st = H_IDLE;
              end
            end
          end
        end
      end
      H_FETCH: begin
        if (s_r.wr_rdy && WR_VALID_IN) begin
          s_nxt.sh = {8'h00, WR_DATA_IN};
          s_nxt.left = s_r.left - 5'h01;
          s_nxt.data_ph = 1'b1;
          s_nxt.tcnt = 8'h00;
          s_nxt.st = H_TXBIT;
        end
      end
      H_RX: begin
        if (bit_ev) begin
          s_nxt.bad = s_r.bad || swt_classify(s_r.lw) == SYM_BAD;
          s_nxt.crc = swt_crc(s_r.crc, bit_val);
          s_nxt.sh = {bit_val, s_r.sh[15:1]};
          s_nxt.txn = s_r.txn + 5'h01;
          if (s_r.txn == 5'h07) begin
            s_nxt.txn = 5'h00;
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data = {bit_val, s_r.sh[15:9]};
            s_nxt.left = s_r.left - 5'h01;
            if (s_r.left == 5'h01) begin
              // Timed from the start of the last bit, so a whole bit time follows its end.
              s_nxt.tcnt = s_r.lw - T_BT;
              s_nxt.st = H_TURN;
            end
          end
        end
      end
      default: begin
        s_nxt.st = H_IDLE;
      end
    endcase
    s_nxt.rdy = (s_nxt.st == H_IDLE);
    s_nxt.wr_rdy = (s_nxt.st == H_FETCH);
    s_nxt.drive = (s_nxt.st == H_BREAK) ||
        (s_nxt.st == H_TXBIT && s_nxt.tcnt < swt_pulse(s_nxt.sh[0]));
  end

  // State register.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s_r <= '0;
      s_r.line_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ports straight from the state register.
  assign LINK.host_o = 1'b0;
  assign LINK.host_oe = s_r.drive;
  assign CMD_READY_OUT = s_r.rdy;
  assign CMD_ERR_OUT = s_r.cmd_err;
  assign WR_READY_OUT = s_r.wr_rdy;
  assign RD_VALID_OUT = s_r.rd_valid;
  assign RD_DATA_OUT = s_r.rd_data;
  assign DONE_OUT = s_r.done;
  assign CRC_ERR_OUT = s_r.crc_err;
endmodule : swt_host
`default_nettype wire

// ==== verification/swt_link_props.sv ====
/*
  Checker for the single wire that joins the host end and the device end.
  Assumes one clock and 37 clocks to each time-base tick.
*/
`timescale 1ns/1ps
`default_nettype none
module swt_link_props (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic line
);
  // A first pulse may start up to one tick before the next tick edge.
  localparam int ONE_LO = 186;
  localparam int ONE_HI = 222;
  localparam int ZERO_LO = 556;
  localparam int ZERO_HI = 592;
  localparam int BRK_LO = 1111;
  localparam int BRK_HI = 1147;
  localparam int BT_LO = 815;
  logic [15:0] dlen_r, hlen_r, dgap_r, hgap_r, hfree_r;
  logic dprev_r, hprev_r;

  // Pulse lengths, spacing of pulse starts and time since the host let go.
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dlen_r <= 16'h0000;
      hlen_r <= 16'h0000;
      dgap_r <= 16'hffff;
      hgap_r <= 16'hffff;
      hfree_r <= 16'hffff;
      dprev_r <= 1'b0;
      hprev_r <= 1'b0;
    end else begin
      dlen_r <= dev_oe ? dlen_r + 16'h0001 : 16'h0000;
      hlen_r <= host_oe ? hlen_r + 16'h0001 : 16'h0000;
      dgap_r <= (dev_oe && !dprev_r) ? 16'h0001 : dgap_r + 16'(!(&dgap_r));
      hgap_r <= (host_oe && !hprev_r) ? 16'h0001 : hgap_r + 16'(!(&hgap_r));
      hfree_r <= host_oe ? 16'h0000 : hfree_r + 16'(!(&hfree_r));
      dprev_r <= dev_oe;
      hprev_r <= host_oe;
    end
  end

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  sequence s_dev_start;
    !dev_oe ##1 dev_oe;
  endsequence
  sequence s_dev_end;
    dev_oe ##1 !dev_oe;
  endsequence
  sequence s_host_end;
    host_oe ##1 !host_oe;
  endsequence

  property p_dev_od;
    dev_o == 1'b0;
  endproperty
  property p_idle_high;
    !dev_oe && !host_oe |-> line;
  endproperty
  property p_excl;
    !(dev_oe && host_oe);
  endproperty
  property p_dev_width;
    s_dev_end |-> dlen_r inside {[ONE_LO:ONE_HI], [ZERO_LO:ZERO_HI]};
  endproperty
  property p_host_width;
    s_host_end |-> hlen_r inside {[ONE_LO:ONE_HI], [ZERO_LO:ZERO_HI], [BRK_LO:BRK_HI]};
  endproperty
  property p_dev_period;
    $rose(dev_oe) |-> dgap_r >= BT_LO;
  endproperty
  property p_host_period;
    $rose(host_oe) |-> hgap_r >= BT_LO;
  endproperty
  property p_dev_ta;
    $rose(dev_oe) |-> hfree_r >= BT_LO;
  endproperty
  property p_dev_hold;
    s_dev_start |=> dev_oe [*8] ##1 !line;
  endproperty

  a_dev_od: assert property (p_dev_od) else $error("device drives the wire high");
  a_idle_high: assert property (p_idle_high) else $error("idle wire not high");
  a_excl: assert property (p_excl) else $error("both ends pull the wire");
  a_dev_width: assert property (p_dev_width) else $error("device pulse width");
  a_host_width: assert property (p_host_width) else $error("host pulse width");
  a_dev_period: assert property (p_dev_period) else $error("device bit spacing");
  a_host_period: assert property (p_host_period) else $error("host bit spacing");
  a_dev_ta: assert property (p_dev_ta) else $error("device turn-around short");
  a_dev_hold: assert property (p_dev_hold) else $error("device pulse too short");
endmodule : swt_link_props
`default_nettype wire

// ==== verification/single_wire_transaction_crc_bench.sv ====
/*
  Bench that joins host and device ends and plays the users of both.
  Assumes the bench answers device reads from a byte array.
*/
`timescale 1ns/1ps
`default_nettype none
module single_wire_transaction_crc_bench;
  import swt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_v = 1'b0;
  logic brk = 1'b0;
  logic lock = 1'b1;
  logic cs_sel = 1'b0;
  logic hw_v = 1'b0;
  logic dw_rdy = 1'b0;
  logic stall = 1'b0;
  logic rd_v = 1'b0;
  logic pop_h = 1'b0;
  logic [7:0] hw_d = 8'h00;
  logic [7:0] rd_d = 8'h00;
  swt_instr_s cmd_f = '0;
  logic cmd_rdy, cmd_err, hr_v, done, crc_err, hw_rdy, dw_v, rd_req, bus_err, sleep;
  logic [7:0] hr_d, wr_addr, wr_data, rd_addr;
  swt_bank_e wr_bank, rd_bank;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int errs = 0;
  int dones = 0;
  logic [7:0] mem [0:1023];
  logic [17:0] exp_wr [$];
  logic [7:0] exp_rd [$];
  logic [7:0] hq [$];
  swt_instr_s bad [10];

  swt_link_if swt_link_if_i ();
  swt_device swt_device_i (.MCLK_IN(clk), .ARST_N_IN(rst_n), .LINK(swt_link_if_i),
    .CHIP_SEL_IN(cs_sel), .WR_VALID_OUT(dw_v), .WR_READY_IN(dw_rdy), .WR_BANK_OUT(wr_bank),
    .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data), .RD_REQ_OUT(rd_req), .RD_BANK_OUT(rd_bank),
    .RD_ADDR_OUT(rd_addr), .RD_VALID_IN(rd_v), .RD_DATA_IN(rd_d), .BUS_ERR_OUT(bus_err),
    .SLEEP_OUT(sleep));
  swt_host swt_host_i (.MCLK_IN(clk), .ARST_N_IN(rst_n), .LINK(swt_link_if_i),
    .CMD_VALID_IN(cmd_v), .CMD_READY_OUT(cmd_rdy), .CMD_FRAME_IN(cmd_f), .CMD_BREAK_IN(brk),
    .OTP_LOCKED_IN(lock), .CMD_ERR_OUT(cmd_err), .WR_VALID_IN(hw_v), .WR_READY_OUT(hw_rdy),
    .WR_DATA_IN(hw_d), .RD_VALID_OUT(hr_v), .RD_DATA_OUT(hr_d), .DONE_OUT(done),
    .CRC_ERR_OUT(crc_err));
  swt_link_props swt_link_props_i (.MCLK_IN(clk), .ARST_N_IN(rst_n),
    .dev_o(swt_link_if_i.dev_o), .dev_oe(swt_link_if_i.dev_oe), .host_o(swt_link_if_i.host_o),
    .host_oe(swt_link_if_i.host_oe), .line(swt_link_if_i.line));

  // The clock runs at 20 MHz.
  always #25 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  function automatic swt_instr_s mk(swt_op_e o, swt_bank_e b, logic [7:0] a, logic [2:0] n);
    mk = '{cnt: n, addr: a, bank: b, op: o, cs: 1'b0};
  endfunction : mk

  // Presents one command and waits for its refusal or its completion.
  task automatic send(input swt_instr_s f, input logic b, input logic refuse);
    int d0;
    d0 = dones;
    @(posedge clk);
    #2;
    while (cmd_rdy !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    cmd_f = f;
    brk = b;
    cmd_v = 1'b1;
    @(posedge clk);
    #2 cmd_v = 1'b0;
    chk("cmd refused", 32'(refuse), 32'(cmd_err));
    chk("cmd ready", 32'(refuse), 32'(cmd_rdy));
    while (!refuse && dones == d0) begin
      @(posedge clk);
      #2;
    end
  endtask : send

  // Compares each delivered byte with the model between clock edges.
  always @(negedge clk) begin
    pop_h = hw_v && hw_rdy;
    if (dw_v && dw_rdy) chk("wr entry", exp_wr.size() ? exp_wr.pop_front() : 32'hffff_ffff,
      {wr_bank, wr_addr, wr_data});
    if (hr_v) chk("rd byte", exp_rd.size() ? exp_rd.pop_front() : 32'hffff_ffff, hr_d);
    if (bus_err) errs++;
    if (done) dones++;
  end

  // Drives write bytes, the write consumer and the read answers after each edge.
  always @(posedge clk) begin
    #2;
    if (pop_h) hq.delete(0);
    hw_v = hq.size() > 0;
    hw_d = hw_v ? hq[0] : 8'h00;
    dw_rdy = !stall && ($urandom_range(1) == 1);
    rd_v = rd_req && ($urandom_range(1) == 1);
    rd_d = mem[{rd_bank, rd_addr}];
  end

  // The whole run needs some 120000 clocks.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 150000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    logic [7:0] a;
    logic [7:0] c;
    swt_instr_s f;
    void'($urandom(6));
    foreach (mem[i]) mem[i] = 8'($urandom);
    bad = '{mk(OP_READ, BANK_CTRL, 8'h00, 3'h0), mk(OP_READ, BANK_CTRL, 8'h00, 3'h3),
      mk(OP_WRITE, BANK_CTRL, 8'h00, 3'h5), mk(OP_READ, BANK_TEST, 8'h00, 3'h6),
      mk(OP_WRITE, BANK_OTP, 8'h01, 3'h4), mk(OP_READ, BANK_OTP, 8'h02, 3'h2),
      mk(OP_READ_CRC, BANK_OTP, 8'h01, 3'h7), mk(OP_READ, BANK_CTRL, 8'h00, 3'h4),
      mk(OP_READ, BANK_AUTH, 8'h01, 3'h4), mk(OP_READ, BANK_OTP, 8'h01, 3'h1)};
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    foreach (bad[i]) send(bad[i], 1'b0, 1'b1);
    lock = 1'b0;
    a = 8'($urandom) | 8'h01;
    for (int i = 0; i < 2; i++) exp_rd.push_back(mem[{2'b00, 8'(a + i)}]);
    c = 8'h00;
    foreach (exp_rd[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ exp_rd[i][k]) ? CRC_POLY : 8'h00);
    exp_rd.push_back(c);
    send(mk(OP_READ_CRC, BANK_OTP, a, 3'h2), 1'b1, 1'b0);
    chk("crc flag", 32'h0, 32'(crc_err));
    chk("rd left", 32'h0, exp_rd.size());
    stall = 1'b1;
    errs = 0;
    for (int i = 0; i < 4; i++) begin
      hq.push_back(8'($urandom));
      if (i < 2) exp_wr.push_back({BANK_AUTH, 8'(CHALLENGE_ADDR + i), hq[i]});
    end
    send(mk(OP_WRITE, BANK_AUTH, CHALLENGE_ADDR, 3'h4), 1'b0, 1'b0);
    chk("overflow errors", 32'h2, errs);
    chk("buffer held", 32'h1, 32'(dw_v));
    stall = 1'b0;
    for (int n = 0; n < 60 && exp_wr.size() > 0; n++) @(posedge clk);
    chk("buffer drained", 32'h0, exp_wr.size());
    f = mk(OP_WRITE, BANK_CTRL, 8'h00, 3'h1);
    f.cs = 1'b1;
    hq.push_back(8'h5a);
    send(f, 1'b0, 1'b0);
    chk("ignored", 32'h0, 32'(dw_v));
    send(mk(OP_SLEEP, BANK_CTRL, 8'h00, 3'h0), 1'b1, 1'b0);
    chk("sleep", 32'h1, 32'(sleep));
    summarize();
  end
endmodule : single_wire_transaction_crc_bench
`default_nettype wire
